// ### verilog/ppm_port_ctrl.v
// Purpose: pin mode and output mode control for ports 1 to 3, data latch control for ports 2 and 3
// Assumes: register bus and peripheral controls synchronous to CLK
// Notes: pin drive outputs are registered, one cycle behind their sources
//
// Notes on behaviour
// [RULE_01] input-mode 0: analog, digital read gives 0
// [RULE_02] analog pin: weak pullup always off
// [RULE_03] input-mode 1: read returns pin level
// [RULE_04] digital pin pullup follows global disable bit
// [RULE_05] output-mode 0 open-drain, 1 push-pull; reset zeros
// [RULE_06] latch 0 drives low; 1 high or released
// [RULE_07] latch reaches pin only if crossbar leaves it
// [RULE_08] data reads return pin levels; read-modify-write reads return the latch
// [RULE_09] bus lines and mode-0 receive forced open-drain
// [RULE_10] analog port 2 bit 0 never skipped
// [RULE_11] analog port 2 bit 1 never skipped
// [RULE_12] memory interface may drive port 2 address
// [RULE_13] memory interface may drive port 3 data
// [RULE_14] data regs bit addressable, all pages, reset ones
// [RULE_15] input-mode registers reset to all ones
// [RULE_16] global pullup disable 1 turns pullups off
// [RULE_17] crossbar disabled forces every pin to input
// [RULE_18] pin levels synchronised in two stages before reading
`timescale 1ns/1ns
`default_nettype none
`include "ppm_defines.vh"

module ppm_port_ctrl (
    input wire CLK,
    input wire SYS_RST,
    // register bus
    input wire [7:0] SFR_PAGE,
    input wire [7:0] SFR_ADDR,
    input wire SFR_WE,
    input wire [7:0] SFR_WDATA,
    input wire SFR_BIT_WE,
    input wire [2:0] SFR_BIT_SEL,
    input wire SFR_BIT_VAL,
    input wire SFR_RE,
    input wire SFR_RMW,
    output reg [7:0] SFR_RDATA,
    // global crossbar controls
    input wire XBAR_ENABLE,
    input wire GLOBAL_PULLUP_DISABLE,
    // port 1 latch is held outside this block
    input wire [7:0] P1_LATCH,
    // crossbar assignment per port
    input wire [7:0] P1_XBAR_SEL,
    input wire [7:0] P1_XBAR_OUT,
    input wire [7:0] P1_XBAR_FORCE_OD,
    input wire [7:0] P2_XBAR_SEL,
    input wire [7:0] P2_XBAR_OUT,
    input wire [7:0] P2_XBAR_FORCE_OD,
    input wire [7:0] P3_XBAR_SEL,
    input wire [7:0] P3_XBAR_OUT,
    input wire [7:0] P3_XBAR_FORCE_OD,
    // external memory interface takeover
    input wire EMIF_P2_EN,
    input wire [7:0] EMIF_P2_OUT,
    input wire EMIF_P3_EN,
    input wire [7:0] EMIF_P3_OUT,
    input wire EMIF_P3_DRIVE,
    // crossbar skip masks
    output wire [7:0] P1_SKIP,
    output wire [7:0] P2_SKIP,
    output wire [7:0] P3_SKIP,
    // pins
    input wire [7:0] P1_PIN_I,
    output reg [7:0] P1_PIN_O,
    output reg [7:0] P1_PIN_OE,
    output reg [7:0] P1_PULLUP_EN,
    input wire [7:0] P2_PIN_I,
    output reg [7:0] P2_PIN_O,
    output reg [7:0] P2_PIN_OE,
    output reg [7:0] P2_PULLUP_EN,
    input wire [7:0] P3_PIN_I,
    output reg [7:0] P3_PIN_O,
    output reg [7:0] P3_PIN_OE,
    output reg [7:0] P3_PULLUP_EN
);

    // register state, indexed 1..3 by port where it exists
    reg [7:0] p2_latch_q; // port2_data_latch
    reg [7:0] p3_latch_q; // port3_data_latch
    reg [7:0] out_mode_q [1:3]; // portN_output_mode
    reg [7:0] in_mode_q [1:3]; // portN_input_mode
    reg [7:0] p2_latch_d;
    reg [7:0] p3_latch_d;
    reg [7:0] rdata_d;

    // synchronised pin levels
    wire [7:0] p1_sync;
    wire [7:0] p2_sync;
    wire [7:0] p3_sync;

    // address decode helpers
    wire page_is_mode;
    wire hit_p2;
    wire hit_p3;

    // the source value presented to each pin
    reg [7:0] p1_src;
    reg [7:0] p2_src;
    reg [7:0] p3_src;
    // push-pull request after forced open-drain lines are removed
    reg [7:0] p1_pp;
    reg [7:0] p2_pp;
    reg [7:0] p3_pp;
    // extra drive gate, used only by the memory interface on port 3
    reg [7:0] p3_gate;

    integer i;

    // [RULE_18] pins cross into the clock domain before any use
    ppm_pin_sync u_sync1 (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .PIN_IN(P1_PIN_I),
        .PIN_SYNC(p1_sync)
    );

    ppm_pin_sync u_sync2 (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .PIN_IN(P2_PIN_I),
        .PIN_SYNC(p2_sync)
    );

    ppm_pin_sync u_sync3 (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .PIN_IN(P3_PIN_I),
        .PIN_SYNC(p3_sync)
    );

    // digital read path: analog pins read as 0, others as the pin
    function [7:0] read_pins;
        input [7:0] pins;
        input [7:0] in_mode;
        begin
            read_pins = pins & in_mode; // RULE_01 RULE_03
        end
    endfunction

    // output enable: released entirely when crossbar is off
    function [7:0] drive_en;
        input xbar_on;
        input [7:0] src;
        input [7:0] pp;
        input [7:0] gate;
        begin
            if (!xbar_on) begin
                drive_en = 8'h00; // RULE_17
            end else begin
                // low driven unless gate is off, high only when push-pull
                drive_en = (~src | pp) & gate; // RULE_06
            end
        end
    endfunction

    // weak pullup: off for analog, off when globally disabled,
    // and off on a pin that drives itself low
    function [7:0] pullup_en;
        input [7:0] in_mode;
        input pud;
        input [7:0] oe;
        input [7:0] src;
        begin
            pullup_en = in_mode & ~(oe & ~src); // RULE_02
            if (pud) begin
                pullup_en = 8'h00; // RULE_04 RULE_16
            end
        end
    endfunction

    // bit-addressable byte update
    function [7:0] bit_write;
        input [7:0] old;
        input [2:0] sel;
        input val;
        begin
            bit_write = old;
            bit_write[sel] = val;
        end
    endfunction

    // mode registers only answer on their own page
    assign page_is_mode = (SFR_PAGE == `PPM_MODE_PAGE); // RULE_14
    // data latches answer on every page
    assign hit_p2 = (SFR_ADDR == `PPM_ADDR_P2_LATCH); // RULE_14
    assign hit_p3 = (SFR_ADDR == `PPM_ADDR_P3_LATCH); // RULE_14

    // analog pins are skipped by the crossbar, except port 2 bits 0 and 1
    assign P1_SKIP = ~in_mode_q[1];
    assign P2_SKIP = ~in_mode_q[2] & ~`PPM_P2_NOSKIP; // RULE_10 RULE_11
    assign P3_SKIP = ~in_mode_q[3];

    // next latch values from byte or bit writes
    always @* begin
        p2_latch_d = p2_latch_q;
        p3_latch_d = p3_latch_q;
        if (SFR_WE && hit_p2) begin
            p2_latch_d = SFR_WDATA;
        end else if (SFR_BIT_WE && hit_p2) begin
            p2_latch_d = bit_write(p2_latch_q, SFR_BIT_SEL, SFR_BIT_VAL); // RULE_14
        end
        if (SFR_WE && hit_p3) begin
            p3_latch_d = SFR_WDATA;
        end else if (SFR_BIT_WE && hit_p3) begin
            p3_latch_d = bit_write(p3_latch_q, SFR_BIT_SEL, SFR_BIT_VAL); // RULE_14
        end
    end

    // register writes; byte write wins over a bit write in the same cycle
    always @(posedge CLK) begin
        if (SYS_RST) begin
            p2_latch_q <= `PPM_RST_LATCH; // RULE_14
            p3_latch_q <= `PPM_RST_LATCH; // RULE_14
            for (i = 1; i <= 3; i = i + 1) begin
                out_mode_q[i] <= `PPM_RST_OUT_MODE; // RULE_05
                in_mode_q[i] <= `PPM_RST_IN_MODE; // RULE_15
            end
        end else begin
            p2_latch_q <= p2_latch_d;
            p3_latch_q <= p3_latch_d;
            if (SFR_WE && page_is_mode) begin
                case (SFR_ADDR)
                    `PPM_ADDR_P1_OUT_MODE: begin
                        out_mode_q[1] <= SFR_WDATA;
                    end
                    `PPM_ADDR_P2_OUT_MODE: begin
                        out_mode_q[2] <= SFR_WDATA;
                    end
                    `PPM_ADDR_P3_OUT_MODE: begin
                        out_mode_q[3] <= SFR_WDATA;
                    end
                    `PPM_ADDR_P1_IN_MODE: begin
                        in_mode_q[1] <= SFR_WDATA;
                    end
                    `PPM_ADDR_P2_IN_MODE: begin
                        in_mode_q[2] <= SFR_WDATA;
                    end
                    `PPM_ADDR_P3_IN_MODE: begin
                        in_mode_q[3] <= SFR_WDATA;
                    end
                    default: begin
                        // other addresses belong to other blocks
                    end
                endcase
            end
        end
    end

    // read decode; read-modify-write cycles see the latch, not the pin
    always @* begin
        rdata_d = `PPM_RD_NONE;
        if (hit_p2) begin
            if (SFR_RMW) begin
                rdata_d = p2_latch_q;
            end else begin
                rdata_d = read_pins(p2_sync, in_mode_q[2]); // RULE_08
            end
        end else if (hit_p3) begin
            if (SFR_RMW) begin
                rdata_d = p3_latch_q;
            end else begin
                rdata_d = read_pins(p3_sync, in_mode_q[3]); // RULE_08
            end
        end else if (page_is_mode) begin
            case (SFR_ADDR)
                `PPM_ADDR_P1_OUT_MODE: begin
                    rdata_d = out_mode_q[1];
                end
                `PPM_ADDR_P2_OUT_MODE: begin
                    rdata_d = out_mode_q[2];
                end
                `PPM_ADDR_P3_OUT_MODE: begin
                    rdata_d = out_mode_q[3];
                end
                `PPM_ADDR_P1_IN_MODE: begin
                    rdata_d = in_mode_q[1];
                end
                `PPM_ADDR_P2_IN_MODE: begin
                    rdata_d = in_mode_q[2];
                end
                `PPM_ADDR_P3_IN_MODE: begin
                    rdata_d = in_mode_q[3];
                end
                default: begin
                    rdata_d = `PPM_RD_NONE;
                end
            endcase
        end
    end

    // read data is held until the next read
    always @(posedge CLK) begin
        if (SYS_RST) begin
            SFR_RDATA <= `PPM_RD_NONE;
        end else if (SFR_RE) begin
            SFR_RDATA <= rdata_d;
        end
    end

    // pin source selection: memory interface, then crossbar, then latch
    always @* begin
        // latch only reaches pins the crossbar leaves alone
        p1_src = (P1_XBAR_SEL & P1_XBAR_OUT) | (~P1_XBAR_SEL & P1_LATCH); // RULE_07
        p2_src = (P2_XBAR_SEL & P2_XBAR_OUT) | (~P2_XBAR_SEL & p2_latch_q); // RULE_07
        p3_src = (P3_XBAR_SEL & P3_XBAR_OUT) | (~P3_XBAR_SEL & p3_latch_q); // RULE_07
        p3_gate = 8'hFF;
        if (EMIF_P2_EN) begin
            p2_src = EMIF_P2_OUT; // RULE_12
        end
        if (EMIF_P3_EN) begin
            p3_src = EMIF_P3_OUT; // RULE_13
            // a bus read turns the data drivers off
            p3_gate = {8{EMIF_P3_DRIVE}}; // RULE_13
        end
        // bus lines and mode-0 receive lines stay open-drain
        p1_pp = out_mode_q[1] & ~(P1_XBAR_SEL & P1_XBAR_FORCE_OD); // RULE_05 RULE_09
        p2_pp = out_mode_q[2] & ~(P2_XBAR_SEL & P2_XBAR_FORCE_OD); // RULE_05 RULE_09
        p3_pp = out_mode_q[3] & ~(P3_XBAR_SEL & P3_XBAR_FORCE_OD); // RULE_05 RULE_09
    end

    // registered pin drive; reset leaves every pin as a pulled-up input
    always @(posedge CLK) begin
        if (SYS_RST) begin
            P1_PIN_O <= 8'hFF;
            P1_PIN_OE <= 8'h00;
            P1_PULLUP_EN <= 8'hFF;
            P2_PIN_O <= 8'hFF;
            P2_PIN_OE <= 8'h00;
            P2_PULLUP_EN <= 8'hFF;
            P3_PIN_O <= 8'hFF;
            P3_PIN_OE <= 8'h00;
            P3_PULLUP_EN <= 8'hFF;
        end else begin
            P1_PIN_O <= p1_src; // RULE_06
            P1_PIN_OE <= drive_en(XBAR_ENABLE, p1_src, p1_pp, 8'hFF);
            P1_PULLUP_EN <= pullup_en(in_mode_q[1], GLOBAL_PULLUP_DISABLE,
                drive_en(XBAR_ENABLE, p1_src, p1_pp, 8'hFF), p1_src);
            P2_PIN_O <= p2_src; // RULE_06
            P2_PIN_OE <= drive_en(XBAR_ENABLE, p2_src, p2_pp, 8'hFF);
            P2_PULLUP_EN <= pullup_en(in_mode_q[2], GLOBAL_PULLUP_DISABLE,
                drive_en(XBAR_ENABLE, p2_src, p2_pp, 8'hFF), p2_src);
            P3_PIN_O <= p3_src; // RULE_06
            P3_PIN_OE <= drive_en(XBAR_ENABLE, p3_src, p3_pp, p3_gate);
            P3_PULLUP_EN <= pullup_en(in_mode_q[3], GLOBAL_PULLUP_DISABLE,
                drive_en(XBAR_ENABLE, p3_src, p3_pp, p3_gate), p3_src);
        end
    end

endmodule

`default_nettype wire

// ### verilog/ppm_defines.vh
// Purpose: constants for the port pin mode control block
// Assumes: 8-bit register bus with an 8-bit page number
// Notes: definitions only
`ifndef PPM_DEFINES_VH
`define PPM_DEFINES_VH

// register addresses
`define PPM_ADDR_P2_LATCH 8'hA0
`define PPM_ADDR_P1_OUT_MODE 8'hA5
`define PPM_ADDR_P2_OUT_MODE 8'hA6
`define PPM_ADDR_P3_OUT_MODE 8'hA7
`define PPM_ADDR_P1_IN_MODE 8'hAD
`define PPM_ADDR_P2_IN_MODE 8'hAE
`define PPM_ADDR_P3_IN_MODE 8'hAF
`define PPM_ADDR_P3_LATCH 8'hB0

// page holding the mode registers
`define PPM_MODE_PAGE 8'h0F

// reset values
`define PPM_RST_LATCH 8'hFF
`define PPM_RST_OUT_MODE 8'h00
`define PPM_RST_IN_MODE 8'hFF

// answer on an unmapped read
`define PPM_RD_NONE 8'h00

// port 2 bits never skipped even when analog
`define PPM_P2_NOSKIP 8'h03

`endif

// ### verilog/ppm_pin_sync.v
// Purpose: two-stage synchroniser for one 8-bit port of pin levels
// Assumes: pin levels may change at any time
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none

module ppm_pin_sync (
    input wire CLK,
    input wire SYS_RST,
    input wire [7:0] PIN_IN,
    output wire [7:0] PIN_SYNC
);

    reg [7:0] meta_q; // first stage, may be metastable
    reg [7:0] sync_q; // second stage, safe to use

    // both stages reset high, matching a pulled-up idle pin
    always @(posedge CLK) begin
        if (SYS_RST) begin
            meta_q <= 8'hFF;
            sync_q <= 8'hFF;
        end else begin
            meta_q <= PIN_IN;
            sync_q <= meta_q;
        end
    end

    assign PIN_SYNC = sync_q;

endmodule

`default_nettype wire

// ### tb/ppm_port_ctrl_sva.sv
// Purpose: port-level checks on the pin drive outputs
// Assumes: one clock domain, synchronous active-high reset
// Notes: outputs are registered, so causes are one edge earlier
`timescale 1ns/1ns
`default_nettype none

module ppm_port_ctrl_chk (
    input wire CLK,
    input wire SYS_RST,
    input wire XBAR_ENABLE,
    input wire GLOBAL_PULLUP_DISABLE,
    input wire [7:0] P1_XBAR_SEL,
    input wire [7:0] P1_XBAR_OUT,
    input wire [7:0] P1_XBAR_FORCE_OD,
    input wire EMIF_P2_EN,
    input wire [7:0] EMIF_P2_OUT,
    input wire EMIF_P3_EN,
    input wire EMIF_P3_DRIVE,
    input wire [7:0] P2_SKIP,
    input wire [7:0] P1_PIN_O,
    input wire [7:0] P1_PIN_OE,
    input wire [7:0] P1_PULLUP_EN,
    input wire [7:0] P2_PIN_O,
    input wire [7:0] P2_PIN_OE,
    input wire [7:0] P2_PULLUP_EN,
    input wire [7:0] P3_PIN_OE,
    input wire [7:0] P3_PULLUP_EN
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    // a memory bus read cycle on port 3
    sequence s_p3_bus_read;
        EMIF_P3_EN && !EMIF_P3_DRIVE;
    endsequence
    a_xbar_off_noe: assert property (!XBAR_ENABLE |=> (P1_PIN_OE | P2_PIN_OE | P3_PIN_OE) == 8'h00)
        else $error("drive enabled while crossbar off");
    a_p2_no_skip: assert property (P2_SKIP[1:0] == 2'b00)
        else $error("port 2 low bits skipped");
    a_pullup_global_off: assert property (GLOBAL_PULLUP_DISABLE |=>
        (P1_PULLUP_EN | P2_PULLUP_EN | P3_PULLUP_EN) == 8'h00)
        else $error("pullup on while globally disabled");
    a_pullup_low_off: assert property ((P1_PIN_OE & ~P1_PIN_O & P1_PULLUP_EN) == 8'h00)
        else $error("pullup fights own low drive");
    a_force_od_high: assert property (1'b1 |=>
        (P1_PIN_OE & P1_PIN_O & $past(P1_XBAR_SEL & P1_XBAR_FORCE_OD)) == 8'h00)
        else $error("forced open-drain pin driven high");
    a_xbar_value: assert property (P1_XBAR_SEL != 8'h00 |=>
        ((P1_PIN_O ^ $past(P1_XBAR_OUT)) & $past(P1_XBAR_SEL)) == 8'h00)
        else $error("peripheral value not on pin");
    a_emif_p2_addr: assert property (EMIF_P2_EN |=> P2_PIN_O == $past(EMIF_P2_OUT))
        else $error("memory address not on port 2");
    a_emif_p3_release: assert property (s_p3_bus_read |=> P3_PIN_OE == 8'h00)
        else $error("port 3 driven during bus read");
endmodule

bind ppm_port_ctrl ppm_port_ctrl_chk u_chk (.*);
`default_nettype wire

// ### tb/ppm_board.sv
// Purpose: board wiring seen by one 8-bit port
// Assumes: external drive only on pins the device leaves undriven
// Notes: a floating pin toggles each cycle so it never reads as a stable level
`timescale 1ns/1ns
`default_nettype none

module ppm_board (
    input wire logic clk,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_en,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pin
);
    logic [7:0] flt_q = 8'h00; // level shown by a floating pin
    always @(posedge clk) begin
        flt_q <= ~flt_q;
    end
    // device drive first, then board drive, then weak pullup
    always @* begin
        pin = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val);
        pin = pin | (~pin_oe & ~ext_en & (pull_en | flt_q));
    end
endmodule
`default_nettype wire

// ### tb/port_pin_mode_control_bench.sv
// Purpose: self-checking bench for the port pin mode control block
// Assumes: inputs change on the falling edge only
// Notes: register rows first, then hand-written pin cases
`timescale 1ns/1ns
`default_nettype none
`include "ppm_defines.vh"

module port_pin_mode_control_bench;
    logic CLK = 1'b0, SYS_RST = 1'b1, SFR_WE = 1'b0, SFR_BIT_WE = 1'b0, SFR_BIT_VAL = 1'b0;
    logic SFR_RE = 1'b0, SFR_RMW = 1'b0, XBAR_ENABLE = 1'b1, GLOBAL_PULLUP_DISABLE = 1'b0;
    logic EMIF_P2_EN = 1'b0, EMIF_P3_EN = 1'b0, EMIF_P3_DRIVE = 1'b0;
    logic [2:0] SFR_BIT_SEL = 3'h0;
    logic [7:0] SFR_PAGE = `PPM_MODE_PAGE, SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, P1_LATCH = 8'hFF;
    logic [7:0] P1_XBAR_SEL = 8'h00, P1_XBAR_OUT = 8'h00, P1_XBAR_FORCE_OD = 8'h00;
    logic [7:0] P2_XBAR_SEL = 8'h00, P2_XBAR_OUT = 8'h00, P2_XBAR_FORCE_OD = 8'h00;
    logic [7:0] P3_XBAR_SEL = 8'h00, P3_XBAR_OUT = 8'h00, P3_XBAR_FORCE_OD = 8'h00;
    logic [7:0] EMIF_P2_OUT = 8'h00, EMIF_P3_OUT = 8'h00, ext_val = 8'h00, ext_en = 8'h00;
    wire [7:0] SFR_RDATA, P1_SKIP, P2_SKIP, P3_SKIP, P1_PIN_I, P2_PIN_I, P3_PIN_I;
    wire [7:0] P1_PIN_O, P1_PIN_OE, P1_PULLUP_EN, P2_PIN_O, P2_PIN_OE, P2_PULLUP_EN;
    wire [7:0] P3_PIN_O, P3_PIN_OE, P3_PULLUP_EN;
    int n_fail = 0;
    int checks_done = 0;
    // register rows: address, reset value, write pattern
    localparam logic [7:0] ADR [0:8] = '{`PPM_ADDR_P2_LATCH, `PPM_ADDR_P1_OUT_MODE,
        `PPM_ADDR_P2_OUT_MODE, `PPM_ADDR_P3_OUT_MODE, `PPM_ADDR_P1_IN_MODE,
        `PPM_ADDR_P2_IN_MODE, `PPM_ADDR_P3_IN_MODE, `PPM_ADDR_P3_LATCH, 8'h12};
    localparam logic [7:0] RSV [0:8] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'h00};
    localparam logic [7:0] WRV [0:8] = '{8'h5A, 8'h3C, 8'hC3, 8'h81, 8'h7E, 8'hE7, 8'hBD,
        8'hA5, 8'h99};

    ppm_port_ctrl DUT (.*);
    // the board side of each port
    ppm_board B1 (.clk(CLK), .pin_o(P1_PIN_O), .pin_oe(P1_PIN_OE), .pull_en(P1_PULLUP_EN),
        .ext_val(8'h00), .ext_en(8'h00), .pin(P1_PIN_I));
    ppm_board B2 (.clk(CLK), .pin_o(P2_PIN_O), .pin_oe(P2_PIN_OE), .pull_en(P2_PULLUP_EN),
        .ext_val(ext_val), .ext_en(ext_en), .pin(P2_PIN_I));
    ppm_board B3 (.clk(CLK), .pin_o(P3_PIN_O), .pin_oe(P3_PIN_OE), .pull_en(P3_PULLUP_EN),
        .ext_val(8'h00), .ext_en(8'h00), .pin(P3_PIN_I));

    initial begin
        forever #10 CLK = ~CLK;
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge CLK);
    endtask
    // byte write, one-cycle strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge CLK);
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WE = 1'b1;
        @(negedge CLK);
        SFR_WE = 1'b0;
    endtask
    // read, data lands one edge after the strobe
    task automatic rdc(input logic [7:0] a, input logic rmw, input logic [7:0] exp);
        @(negedge CLK);
        SFR_ADDR = a;
        SFR_RMW = rmw;
        SFR_RE = 1'b1;
        @(negedge CLK);
        SFR_RE = 1'b0;
        chk(SFR_RDATA, exp);
    endtask
    // reset long enough to clear the synchronisers
    task automatic do_reset();
        SYS_RST = 1'b1;
        wt(2);
        SYS_RST = 1'b0;
        wt(4);
        for (int i = 0; i < 9; i++) rdc(ADR[i], 1'b0, RSV[i]);
        $display("test reset values done");
    endtask

    initial begin
        repeat (3000) @(posedge CLK);
        n_fail++;
        $display("mismatch at %0t: run too long", $time);
        finish_test();
    end

    initial begin
        @(negedge CLK);
        do_reset();
        for (int i = 0; i < 9; i++) wr(ADR[i], WRV[i]);
        for (int i = 0; i < 9; i++) rdc(ADR[i], 1'b1, (i == 8) ? 8'h00 : WRV[i]);
        // mode registers answer only on their page, data latches on all
        SFR_PAGE = 8'h00;
        wr(`PPM_ADDR_P1_OUT_MODE, 8'hFF);
        rdc(`PPM_ADDR_P1_OUT_MODE, 1'b0, 8'h00);
        rdc(`PPM_ADDR_P2_LATCH, 1'b1, 8'h5A);
        SFR_PAGE = `PPM_MODE_PAGE;
        rdc(`PPM_ADDR_P1_OUT_MODE, 1'b0, 8'h3C);
        $display("test registers done");
        do_reset();
        // analog bits read 0, lose pullup, are skipped by the crossbar except port 2 bits 0 and 1
        wr(`PPM_ADDR_P2_IN_MODE, 8'h0C);
        wr(`PPM_ADDR_P1_IN_MODE, 8'h0C);
        wr(`PPM_ADDR_P3_IN_MODE, 8'h3C);
        ext_val = 8'hA5;
        ext_en = 8'hFF;
        wt(4);
        rdc(`PPM_ADDR_P2_LATCH, 1'b0, 8'h04);
        chk(P2_PULLUP_EN, 8'h0C);
        chk(P2_SKIP, 8'hF0);
        chk(P1_SKIP, 8'hF3);
        chk(P3_SKIP, 8'hC3);
        GLOBAL_PULLUP_DISABLE = 1'b1;
        wt(2);
        chk(P2_PULLUP_EN, 8'h00);
        GLOBAL_PULLUP_DISABLE = 1'b0;
        ext_en = 8'h00;
        wr(`PPM_ADDR_P2_IN_MODE, 8'hFF);
        $display("test input modes done");
        // push-pull upper nibble, open-drain lower
        wr(`PPM_ADDR_P2_OUT_MODE, 8'hF0);
        wr(`PPM_ADDR_P2_LATCH, 8'h3C);
        wt(2);
        chk(P2_PIN_O, 8'h3C);
        chk(P2_PIN_OE, 8'hF3);
        chk(P2_PULLUP_EN, 8'h3C);
        @(negedge CLK);
        SFR_ADDR = `PPM_ADDR_P2_LATCH;
        SFR_BIT_SEL = 3'h0;
        SFR_BIT_VAL = 1'b1;
        SFR_BIT_WE = 1'b1;
        @(negedge CLK);
        SFR_BIT_WE = 1'b0;
        wt(4);
        chk(P2_PIN_OE, 8'hF2);
        rdc(`PPM_ADDR_P2_LATCH, 1'b0, 8'h3D);
        $display("test output drive done");
        // crossbar takes the low nibble, bit 0 forced open-drain
        wr(`PPM_ADDR_P2_OUT_MODE, 8'hFF);
        P1_LATCH = 8'h3D;
        {P1_XBAR_SEL, P2_XBAR_SEL, P3_XBAR_SEL} = {3{8'h0F}};
        {P1_XBAR_OUT, P2_XBAR_OUT, P3_XBAR_OUT} = {3{8'h05}};
        {P1_XBAR_FORCE_OD, P2_XBAR_FORCE_OD, P3_XBAR_FORCE_OD} = {3{8'h01}};
        wt(4);
        chk(P2_PIN_O, 8'h35);
        chk(P2_PIN_OE, 8'hFE);
        chk(P1_PIN_O, 8'h35);
        chk(P1_PIN_OE, 8'hCA);
        chk(P3_PIN_O, 8'hF5);
        chk(P3_PIN_OE, 8'h0A);
        // push-pull on port 1 must still leave the forced bit open-drain
        wr(`PPM_ADDR_P1_OUT_MODE, 8'hFF);
        wt(2);
        chk(P1_PIN_OE, 8'hFE);
        rdc(`PPM_ADDR_P2_LATCH, 1'b0, 8'h35);
        rdc(`PPM_ADDR_P2_LATCH, 1'b1, 8'h3D);
        XBAR_ENABLE = 1'b0;
        wt(2);
        chk(P1_PIN_OE | P2_PIN_OE | P3_PIN_OE, 8'h00);
        XBAR_ENABLE = 1'b1;
        {P1_XBAR_SEL, P2_XBAR_SEL, P3_XBAR_SEL} = {3{8'h00}};
        $display("test crossbar done");
        // memory interface owns ports 2 and 3
        EMIF_P2_EN = 1'b1;
        EMIF_P2_OUT = 8'h81;
        EMIF_P3_EN = 1'b1;
        wt(2);
        chk(P2_PIN_O, 8'h81);
        chk(P3_PIN_OE, 8'h00);
        EMIF_P3_DRIVE = 1'b1;
        wt(2);
        chk(P3_PIN_OE, 8'hFF);
        chk(P3_PIN_O, 8'h00);
        $display("test memory interface done");
        finish_test();
    end
endmodule
`default_nettype wire
